/* File: core/aif_pkg.sv */
// Notes on behaviour
// - ARP sender IP/MAC pair is checked against the trusted binding database first.
// - An unauthorized ARP installs a filter on its source MAC and source VLAN.
// - Filters are installed only while inspection is enabled and a host is invalid.
// - Entries whose age time has run out are deleted automatically.
// - Age time is set in whole minutes, 1 to 10080.
// - A new age time only applies to filters created afterwards.
// - Link down on a port removes all filters learned there, enabled or not.
// - The table holds at most 256 entries.
// - Unauthorized ARP with a full table is dropped; log raised only the first time in each full spell.
// - Clear command removes every entry at once.
// - Delete command with MAC and VLAN 1 to 4094 removes only that entry.
// - Each entry keeps MAC, VLAN, ingress port and remaining minutes, readable.
// - Each entry reports its index; a running total of created filters is kept.
// - ARP on trusted ports is never discarded and never creates a filter.
// - Inspection runs on a VLAN only if global and per-VLAN enables are both set.
package aif_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_VLAN_EN = 8'h04;
    localparam logic [7:0] ADDR_TRUST = 8'h08;
    localparam logic [7:0] ADDR_AGE = 8'h0c;
    localparam logic [7:0] ADDR_CMD = 8'h10;
    localparam logic [7:0] ADDR_DEL_MAC_LO = 8'h14;
    localparam logic [7:0] ADDR_DEL_MAC_HI = 8'h18;
    localparam logic [7:0] ADDR_DEL_VLAN = 8'h1c;
    localparam logic [7:0] ADDR_STAT = 8'h20;
    localparam logic [7:0] ADDR_MASK = 8'h24;
    localparam logic [7:0] ADDR_COUNT = 8'h28;
    localparam logic [7:0] ADDR_TOTAL = 8'h2c;
    localparam logic [7:0] ADDR_RD_IDX = 8'h30;
    localparam logic [7:0] ADDR_ENT_LO = 8'h34;
    localparam logic [7:0] ADDR_ENT_HI = 8'h38;
    localparam logic [7:0] ADDR_ENT_INFO = 8'h3c;

    localparam int CTRL_EN_BIT = 0;
    localparam int VLAN_EN_BIT = 12;
    localparam int CMD_CLEAR_BIT = 0;
    localparam int CMD_DELETE_BIT = 1;
    localparam int STAT_CREATED_BIT = 0;
    localparam int STAT_FULL_BIT = 1;
    localparam int STAT_PURGE_BIT = 2;
    localparam int STAT_W = 3;
    localparam int ENT_HI_VALID_BIT = 31;
    localparam int ENT_HI_IDX_POS = 16;
    localparam int ENT_INFO_VLAN_POS = 16;
    localparam int ENT_INFO_PORT_POS = 28;

    localparam int MAC_W = 48;
    localparam int VID_W = 12;
    localparam int AGE_W = 14;
    localparam int MAX_ENTRIES = 256;
    localparam logic [AGE_W-1:0] AGE_MIN = 14'h0001;
    localparam logic [AGE_W-1:0] AGE_MAX = 14'h2760;
    localparam logic [AGE_W-1:0] AGE_RESET = 14'h0005;
    localparam logic [VID_W-1:0] VID_MIN = 12'h001;
    localparam logic [VID_W-1:0] VID_MAX = 12'hffe;
endpackage

/* File: core/aif_entry.sv */
`timescale 1ns/1ps
module aif_entry #(
    parameter int PORT_W = 3
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic install,
    input wire logic kill,
    input wire logic tick,
    input wire logic [aif_pkg::MAC_W-1:0] in_mac,
    input wire logic [aif_pkg::VID_W-1:0] in_vlan,
    input wire logic [PORT_W-1:0] in_port,
    input wire logic [aif_pkg::AGE_W-1:0] in_life,
    output logic valid_q,
    output logic [aif_pkg::MAC_W-1:0] mac_q,
    output logic [aif_pkg::VID_W-1:0] vlan_q,
    output logic [PORT_W-1:0] port_q,
    output logic [aif_pkg::AGE_W-1:0] remain_q
);
    wire last_minute = (remain_q == aif_pkg::AGE_W'(1));

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            valid_q <= 1'b0;
            mac_q <= '0;
            vlan_q <= '0;
            port_q <= '0;
            remain_q <= '0;
        end
        else if (kill)
        begin
            valid_q <= 1'b0;
        end
        else if (install)
        begin
            // Lifetime latched here, so later age changes leave this entry alone
            valid_q <= 1'b1;
            mac_q <= in_mac;
            vlan_q <= in_vlan;
            port_q <= in_port;
            remain_q <= in_life;
        end
        else if (tick && valid_q)
        begin
            remain_q <= remain_q - aif_pkg::AGE_W'(1);
            if (last_minute)
            begin
                valid_q <= 1'b0;
            end
        end
    end
endmodule

/* File: core/aif_filter_table.sv */
`timescale 1ns/1ps
module aif_filter_table #(
    parameter int NPORT = 8,
    parameter int PORT_W = 3,
    parameter int NENT = 256
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata_q,
    input wire logic arp_valid,
    input wire logic [aif_pkg::MAC_W-1:0] arp_mac,
    input wire logic [aif_pkg::VID_W-1:0] arp_vlan,
    input wire logic [PORT_W-1:0] arp_port,
    input wire logic arp_bind_ok,
    output logic arp_fwd_q,
    output logic arp_drop_q,
    input wire logic frm_valid,
    input wire logic [aif_pkg::MAC_W-1:0] frm_mac,
    input wire logic [aif_pkg::VID_W-1:0] frm_vlan,
    output logic frm_pass_q,
    output logic frm_drop_q,
    input wire logic [NPORT-1:0] link_up,
    input wire logic minute_tick,
    output logic full_log_q,
    output logic irq_q
);
    localparam int IDX_W = $clog2(NENT);
    localparam int CNT_W = $clog2(NENT + 1);

    logic glob_en_q;
    logic vlan_en_q [1 << aif_pkg::VID_W];
    logic [NPORT-1:0] trust_q;
    logic [aif_pkg::AGE_W-1:0] age_q;
    logic [aif_pkg::MAC_W-1:0] del_mac_q;
    logic [aif_pkg::VID_W-1:0] del_vlan_q;
    logic [aif_pkg::STAT_W-1:0] stat_q;
    logic [aif_pkg::STAT_W-1:0] mask_q;
    logic [31:0] total_q;
    logic [IDX_W-1:0] rd_idx_q;
    logic [NPORT-1:0] link_prev_q;
    logic full_seen_q;

    logic e_valid [NENT];
    logic [aif_pkg::MAC_W-1:0] e_mac [NENT];
    logic [aif_pkg::VID_W-1:0] e_vlan [NENT];
    logic [PORT_W-1:0] e_port [NENT];
    logic [aif_pkg::AGE_W-1:0] e_remain [NENT];

    function automatic logic key_hit(
        input logic v,
        input logic [aif_pkg::MAC_W-1:0] ma,
        input logic [aif_pkg::VID_W-1:0] va,
        input logic [aif_pkg::MAC_W-1:0] mb,
        input logic [aif_pkg::VID_W-1:0] vb
    );
        key_hit = v && (ma == mb) && (va == vb);
    endfunction

    wire wr_ctrl = reg_wr && (reg_addr == aif_pkg::ADDR_CTRL);
    wire wr_vlan = reg_wr && (reg_addr == aif_pkg::ADDR_VLAN_EN);
    wire wr_trust = reg_wr && (reg_addr == aif_pkg::ADDR_TRUST);
    wire wr_age = reg_wr && (reg_addr == aif_pkg::ADDR_AGE);
    wire wr_cmd = reg_wr && (reg_addr == aif_pkg::ADDR_CMD);
    wire wr_dlo = reg_wr && (reg_addr == aif_pkg::ADDR_DEL_MAC_LO);
    wire wr_dhi = reg_wr && (reg_addr == aif_pkg::ADDR_DEL_MAC_HI);
    wire wr_dvl = reg_wr && (reg_addr == aif_pkg::ADDR_DEL_VLAN);
    wire wr_stat = reg_wr && (reg_addr == aif_pkg::ADDR_STAT);
    wire wr_mask = reg_wr && (reg_addr == aif_pkg::ADDR_MASK);
    wire wr_idx = reg_wr && (reg_addr == aif_pkg::ADDR_RD_IDX);

    wire [aif_pkg::AGE_W-1:0] age_in = reg_wdata[aif_pkg::AGE_W-1:0];
    wire age_ok = (reg_wdata[31:aif_pkg::AGE_W] == '0) && (age_in >= aif_pkg::AGE_MIN) &&
        (age_in <= aif_pkg::AGE_MAX);
    wire do_clear = wr_cmd && reg_wdata[aif_pkg::CMD_CLEAR_BIT];
    wire vid_ok = (del_vlan_q >= aif_pkg::VID_MIN) && (del_vlan_q <= aif_pkg::VID_MAX);
    wire do_delete = wr_cmd && reg_wdata[aif_pkg::CMD_DELETE_BIT] && vid_ok;
    wire [NPORT-1:0] link_fall = link_prev_q & ~link_up;

    // Inspection decision for the ARP presented this cycle
    wire arp_trusted = trust_q[arp_port];
    wire arp_inspect = glob_en_q && vlan_en_q[arp_vlan] && !arp_trusted;
    wire arp_bad = arp_valid && arp_inspect && !arp_bind_ok;

    logic [NENT-1:0] hit_arp;
    logic [NENT-1:0] hit_frm;
    logic [NENT-1:0] kill;
    logic [NENT-1:0] install;
    logic [CNT_W-1:0] used;
    logic free_found;
    logic [IDX_W-1:0] free_idx;

    // Linear scan for the lowest free slot; costs depth, saves a free list
    always_comb
    begin
        free_found = 1'b0;
        free_idx = '0;
        used = '0;
        for (int i = NENT - 1; i >= 0; i--)
        begin
            if (!e_valid[i])
            begin
                free_found = 1'b1;
                free_idx = IDX_W'(i);
            end
            used = used + CNT_W'(e_valid[i]);
        end
    end

    wire table_full = !free_found;
    wire arp_dup = |hit_arp;
    wire do_install = arp_bad && !arp_dup && !table_full;
    wire full_hit = arp_bad && !arp_dup && table_full;
    wire log_now = full_hit && !full_seen_q;

    always_comb
    begin
        for (int i = 0; i < NENT; i++)
        begin
            hit_arp[i] = key_hit(e_valid[i], e_mac[i], e_vlan[i], arp_mac, arp_vlan);
            hit_frm[i] = key_hit(e_valid[i], e_mac[i], e_vlan[i], frm_mac, frm_vlan);
            // A clear in the same cycle as an install wins, so that new filter is never kept
            kill[i] = do_clear || (do_delete && key_hit(e_valid[i], e_mac[i], e_vlan[i], del_mac_q,
                del_vlan_q)) || (e_valid[i] && link_fall[e_port[i]]);
            install[i] = do_install && (free_idx == IDX_W'(i));
        end
    end

    for (genvar g = 0; g < NENT; g++)
    begin : g_ent
        aif_entry #(
            .PORT_W(PORT_W)
        ) u_entry (
            .clock(clock),
            .rst(rst),
            .install(install[g]),
            .kill(kill[g]),
            .tick(minute_tick),
            .in_mac(arp_mac),
            .in_vlan(arp_vlan),
            .in_port(arp_port),
            .in_life(age_q),
            .valid_q(e_valid[g]),
            .mac_q(e_mac[g]),
            .vlan_q(e_vlan[g]),
            .port_q(e_port[g]),
            .remain_q(e_remain[g])
        );
    end

    wire [aif_pkg::STAT_W-1:0] stat_set = {|link_fall, log_now, do_install};
    wire [aif_pkg::STAT_W-1:0] stat_d = (stat_q & ~(wr_stat ? reg_wdata[aif_pkg::STAT_W-1:0] : '0)) |
        stat_set;

    // Entry view; the slot number doubles as the reported sequence number
    wire [31:0] ent_lo = e_mac[rd_idx_q][31:0];
    wire [31:0] ent_hi = {e_valid[rd_idx_q], 15'(rd_idx_q), e_mac[rd_idx_q][47:32]};
    wire [31:0] ent_info = {PORT_W == 4 ? e_port[rd_idx_q] : 4'(e_port[rd_idx_q]),
        e_vlan[rd_idx_q], 2'b00, e_remain[rd_idx_q]};

    logic [31:0] rd_mux;
    always_comb
    begin
        unique case (reg_addr)
            aif_pkg::ADDR_CTRL: rd_mux = 32'(glob_en_q);
            aif_pkg::ADDR_VLAN_EN: rd_mux = 32'h0;
            aif_pkg::ADDR_TRUST: rd_mux = 32'(trust_q);
            aif_pkg::ADDR_AGE: rd_mux = 32'(age_q);
            aif_pkg::ADDR_CMD: rd_mux = 32'h0;
            aif_pkg::ADDR_DEL_MAC_LO: rd_mux = del_mac_q[31:0];
            aif_pkg::ADDR_DEL_MAC_HI: rd_mux = 32'(del_mac_q[47:32]);
            aif_pkg::ADDR_DEL_VLAN: rd_mux = 32'(del_vlan_q);
            aif_pkg::ADDR_STAT: rd_mux = 32'(stat_q);
            aif_pkg::ADDR_MASK: rd_mux = 32'(mask_q);
            aif_pkg::ADDR_COUNT: rd_mux = 32'(used);
            aif_pkg::ADDR_TOTAL: rd_mux = total_q;
            aif_pkg::ADDR_RD_IDX: rd_mux = 32'(rd_idx_q);
            aif_pkg::ADDR_ENT_LO: rd_mux = ent_lo;
            aif_pkg::ADDR_ENT_HI: rd_mux = ent_hi;
            aif_pkg::ADDR_ENT_INFO: rd_mux = ent_info;
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            glob_en_q <= 1'b0;
            trust_q <= '0;
            age_q <= aif_pkg::AGE_RESET;
            del_mac_q <= '0;
            del_vlan_q <= '0;
            mask_q <= '0;
            rd_idx_q <= '0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                glob_en_q <= reg_wdata[aif_pkg::CTRL_EN_BIT];
            end
            if (wr_trust)
            begin
                trust_q <= reg_wdata[NPORT-1:0];
            end
            if (wr_age && age_ok)
            begin
                age_q <= age_in;
            end
            if (wr_dlo)
            begin
                del_mac_q[31:0] <= reg_wdata;
            end
            if (wr_dhi)
            begin
                del_mac_q[47:32] <= reg_wdata[15:0];
            end
            if (wr_dvl)
            begin
                del_vlan_q <= reg_wdata[aif_pkg::VID_W-1:0];
            end
            if (wr_mask)
            begin
                mask_q <= reg_wdata[aif_pkg::STAT_W-1:0];
            end
            if (wr_idx)
            begin
                rd_idx_q <= reg_wdata[IDX_W-1:0];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            for (int i = 0; i < (1 << aif_pkg::VID_W); i++)
            begin
                vlan_en_q[i] <= 1'b0;
            end
        end
        else if (wr_vlan)
        begin
            vlan_en_q[reg_wdata[aif_pkg::VID_W-1:0]] <= reg_wdata[aif_pkg::VLAN_EN_BIT];
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            stat_q <= '0;
            total_q <= '0;
            full_seen_q <= 1'b0;
            link_prev_q <= '0;
            irq_q <= 1'b0;
            reg_rdata_q <= '0;
        end
        else
        begin
            stat_q <= stat_d;
            irq_q <= |(stat_d & mask_q);
            link_prev_q <= link_up;
            reg_rdata_q <= reg_rd ? rd_mux : 32'h0;
            if (do_install)
            begin
                total_q <= total_q + 32'h1;
            end
            // Re-armed once a slot frees, so each new full spell logs again
            if (log_now)
            begin
                full_seen_q <= 1'b1;
            end
            else if (!table_full)
            begin
                full_seen_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            arp_fwd_q <= 1'b0;
            arp_drop_q <= 1'b0;
            frm_pass_q <= 1'b0;
            frm_drop_q <= 1'b0;
            full_log_q <= 1'b0;
        end
        else
        begin
            arp_fwd_q <= arp_valid && !arp_bad;
            arp_drop_q <= arp_bad;
            frm_pass_q <= frm_valid && !(|hit_frm);
            frm_drop_q <= frm_valid && (|hit_frm);
            full_log_q <= log_now;
        end
    end
endmodule

/* File: tb/aif_table_assertions.sv */
`timescale 1ns/1ps
module aif_table_assertions (
    input wire logic clock,
    input wire logic rst,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata_q,
    input wire logic arp_valid,
    input wire logic arp_bind_ok,
    input wire logic arp_fwd_q,
    input wire logic arp_drop_q,
    input wire logic frm_valid,
    input wire logic frm_pass_q,
    input wire logic frm_drop_q,
    input wire logic full_log_q,
    input wire logic irq_q
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    arp_answer_a: assert property (arp_valid |=> arp_fwd_q ^ arp_drop_q)
        else $error("arp packet without a single verdict");
    arp_quiet_a: assert property (!arp_valid |=> !arp_fwd_q && !arp_drop_q)
        else $error("arp verdict without a packet");
    bind_fwd_a: assert property (arp_valid && arp_bind_ok |=> arp_fwd_q)
        else $error("bound arp packet was not forwarded");
    frm_answer_a: assert property (frm_valid |=> frm_pass_q ^ frm_drop_q)
        else $error("frame without a single verdict");
    frm_quiet_a: assert property (!frm_valid |=> !frm_pass_q && !frm_drop_q)
        else $error("frame verdict without a frame");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata_q == 32'h0)
        else $error("read data outside its slot");
    full_log_a: assert property (full_log_q |-> arp_drop_q && $past(arp_valid))
        else $error("full log without a dropped packet");
    rst_quiet_a: assert property ($past(rst) |-> !(arp_drop_q || frm_drop_q || full_log_q || irq_q))
        else $error("output active right after reset");

    cover property (arp_drop_q);
    cover property (frm_drop_q);
    cover property (full_log_q);
endmodule

bind aif_filter_table aif_table_assertions u_chk (.clock(clock), .rst(rst), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .arp_valid(arp_valid), .arp_bind_ok(arp_bind_ok), .arp_fwd_q(arp_fwd_q),
    .arp_drop_q(arp_drop_q), .frm_valid(frm_valid), .frm_pass_q(frm_pass_q), .frm_drop_q(frm_drop_q),
    .full_log_q(full_log_q), .irq_q(irq_q));

/* File: tb/aif_host_model.sv */
`timescale 1ns/1ps
module aif_host_model #(
    parameter int PORT_W = 3
) (
    input wire logic clock,
    output logic arp_valid,
    output logic [47:0] arp_mac,
    output logic [11:0] arp_vlan,
    output logic [PORT_W-1:0] arp_port,
    output logic arp_bind_ok,
    output logic frm_valid,
    output logic [47:0] frm_mac,
    output logic [11:0] frm_vlan,
    input wire logic arp_drop_q,
    input wire logic frm_drop_q,
    input wire logic full_log_q
);
    logic drop;
    logic log_seen;
    initial
    begin
        arp_valid = 1'b0;
        frm_valid = 1'b0;
    end
    // Released MAC fields, and the ARP VLAN, turn to their inverse so a stale value never looks valid
    task arp(input logic [47:0] m, input logic [11:0] v, input logic [PORT_W-1:0] p, input logic ok);
        @(posedge clock);
        arp_valid <= 1'b1;
        arp_mac <= m;
        arp_vlan <= v;
        arp_port <= p;
        arp_bind_ok <= ok;
        @(posedge clock);
        arp_valid <= 1'b0;
        arp_mac <= ~m;
        arp_vlan <= ~v;
        #1;
        drop = arp_drop_q;
        log_seen = full_log_q;
    endtask
    task frm(input logic [47:0] m, input logic [11:0] v);
        @(posedge clock);
        frm_valid <= 1'b1;
        frm_mac <= m;
        frm_vlan <= v;
        @(posedge clock);
        frm_valid <= 1'b0;
        frm_mac <= ~m;
        #1;
        drop = frm_drop_q;
    endtask
endmodule

/* File: tb/aif_filter_table_test.sv */
`timescale 1ns/1ps
module aif_filter_table_test;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata_q;
    logic arp_valid, arp_bind_ok, arp_fwd_q, arp_drop_q, frm_valid, frm_pass_q, frm_drop_q;
    logic [47:0] arp_mac, frm_mac;
    logic [11:0] arp_vlan, frm_vlan;
    logic [2:0] arp_port;
    logic [7:0] link_up = 8'hff;
    logic minute_tick = 1'b0;
    logic full_log_q, irq_q;
    int errors = 0;
    int checks_done = 0;
    localparam logic [47:0] MAC_A = 48'h0a11_2233_4455;
    always #12.5 clock = ~clock;
    // Small table so the full case is reached quickly
    aif_filter_table #(.NENT(4)) u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .arp_valid(arp_valid), .arp_mac(arp_mac),
        .arp_vlan(arp_vlan), .arp_port(arp_port), .arp_bind_ok(arp_bind_ok), .arp_fwd_q(arp_fwd_q),
        .arp_drop_q(arp_drop_q), .frm_valid(frm_valid), .frm_mac(frm_mac), .frm_vlan(frm_vlan),
        .frm_pass_q(frm_pass_q), .frm_drop_q(frm_drop_q), .link_up(link_up), .minute_tick(minute_tick),
        .full_log_q(full_log_q), .irq_q(irq_q));
    aif_host_model u_host (.clock(clock), .arp_valid(arp_valid), .arp_mac(arp_mac), .arp_vlan(arp_vlan),
        .arp_port(arp_port), .arp_bind_ok(arp_bind_ok), .frm_valid(frm_valid), .frm_mac(frm_mac),
        .frm_vlan(frm_vlan), .arp_drop_q(arp_drop_q), .frm_drop_q(frm_drop_q), .full_log_q(full_log_q));
    task wrap_up;
        if (errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task rc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata_q, exp);
    endtask
    task tick;
        @(posedge clock);
        minute_tick <= 1'b1;
        @(posedge clock);
        minute_tick <= 1'b0;
    endtask
    initial
    begin
        repeat (20000) @(posedge clock);
        errors++;
        wrap_up;
    end
    initial
    begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        rc(aif_pkg::ADDR_AGE, 32'h5);
        rc(aif_pkg::ADDR_COUNT, 32'h0);
        rc(8'h40, 32'h0);
        wr(aif_pkg::ADDR_CTRL, 32'h1);
        wr(aif_pkg::ADDR_VLAN_EN, 32'h100a);
        wr(aif_pkg::ADDR_TRUST, 32'h2);
        wr(aif_pkg::ADDR_MASK, 32'h7);
        rc(aif_pkg::ADDR_CTRL, 32'h1);
        rc(aif_pkg::ADDR_TRUST, 32'h2);
        rc(aif_pkg::ADDR_MASK, 32'h7);
        u_host.arp(MAC_A, 12'h00b, 3'd2, 1'b0);
        chk(32'(u_host.drop), 32'h0);
        u_host.arp(MAC_A, 12'h00a, 3'd1, 1'b0);
        chk(32'(u_host.drop), 32'h0);
        u_host.arp(MAC_A, 12'h00a, 3'd2, 1'b1);
        chk(32'(u_host.drop), 32'h0);
        u_host.arp(MAC_A, 12'h00a, 3'd2, 1'b0);
        chk(32'(u_host.drop), 32'h1);
        rc(aif_pkg::ADDR_STAT, 32'h1);
        chk(32'(irq_q), 32'h1);
        wr(aif_pkg::ADDR_STAT, 32'h1);
        rc(aif_pkg::ADDR_STAT, 32'h0);
        chk(32'(irq_q), 32'h0);
        wr(aif_pkg::ADDR_RD_IDX, 32'h0);
        rc(aif_pkg::ADDR_ENT_LO, 32'h2233_4455);
        rc(aif_pkg::ADDR_ENT_HI, 32'h8000_0a11);
        rc(aif_pkg::ADDR_ENT_INFO, 32'h200a_0005);
        u_host.frm(MAC_A, 12'h00a);
        chk(32'(u_host.drop), 32'h1);
        u_host.frm(MAC_A, 12'h00b);
        chk(32'(u_host.drop), 32'h0);
        wr(aif_pkg::ADDR_AGE, 32'h0);
        wr(aif_pkg::ADDR_AGE, 32'h2761);
        rc(aif_pkg::ADDR_AGE, 32'h5);
        wr(aif_pkg::ADDR_AGE, 32'h2760);
        rc(aif_pkg::ADDR_AGE, 32'h2760);
        wr(aif_pkg::ADDR_AGE, 32'h2);
        u_host.arp(48'h0a66_7788_99aa, 12'h00a, 3'd3, 1'b0);
        wr(aif_pkg::ADDR_RD_IDX, 32'h1);
        rc(aif_pkg::ADDR_ENT_INFO, 32'h300a_0002);
        repeat (2) tick;
        rc(aif_pkg::ADDR_COUNT, 32'h1);
        wr(aif_pkg::ADDR_RD_IDX, 32'h0);
        rc(aif_pkg::ADDR_ENT_INFO, 32'h200a_0003);
        wr(aif_pkg::ADDR_DEL_MAC_LO, 32'h2233_4455);
        wr(aif_pkg::ADDR_DEL_MAC_HI, 32'h0a11);
        wr(aif_pkg::ADDR_DEL_VLAN, 32'h0);
        wr(aif_pkg::ADDR_CMD, 32'h2);
        rc(aif_pkg::ADDR_COUNT, 32'h1);
        wr(aif_pkg::ADDR_DEL_VLAN, 32'ha);
        rc(aif_pkg::ADDR_DEL_VLAN, 32'ha);
        rc(aif_pkg::ADDR_DEL_MAC_HI, 32'h0a11);
        wr(aif_pkg::ADDR_CMD, 32'h2);
        rc(aif_pkg::ADDR_COUNT, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            u_host.arp(48'h0b00_0000_0000 + 48'(i), 12'h00a, 3'(4 + i / 2), 1'b0);
            chk(32'(u_host.drop), 32'h1);
        end
        for (int i = 0; i < 2; i++)
        begin
            u_host.arp(48'h0c00_0000_0000, 12'h00a, 3'd4, 1'b0);
            chk(32'(u_host.drop), 32'h1);
            chk(32'(u_host.log_seen), 32'(i == 0));
        end
        rc(aif_pkg::ADDR_COUNT, 32'h4);
        wr(aif_pkg::ADDR_RD_IDX, 32'h3);
        rc(aif_pkg::ADDR_ENT_HI, 32'h8003_0b00);
        rc(aif_pkg::ADDR_ENT_INFO, 32'h500a_0002);
        wr(aif_pkg::ADDR_CTRL, 32'h0);
        u_host.arp(MAC_A, 12'h00a, 3'd2, 1'b0);
        chk(32'(u_host.drop), 32'h0);
        @(posedge clock);
        link_up[4] <= 1'b0;
        rc(aif_pkg::ADDR_COUNT, 32'h2);
        rc(aif_pkg::ADDR_STAT, 32'h7);
        wr(aif_pkg::ADDR_CMD, 32'h1);
        rc(aif_pkg::ADDR_COUNT, 32'h0);
        rc(aif_pkg::ADDR_TOTAL, 32'h6);
        wrap_up;
    end
endmodule
